// *** verilog/cmec_core.sv ***
// Execution mode and event control with an AHB-Lite register slave
// Functional notes
// - Contexts rank NMI 1, exception 2, interrupt 3..0 as 3..6; others unranked.
// - Interrupts preempt only a strictly lower priority mode; exceptions and debug entry are taken in any mode.
// - Mode changes by software write, interrupt request or exception entry.
// - Application context refuses privileged instructions.
// - Application context cannot reach system registers or upper status half.
// - Application context is denied protected memory regions.
// - Every non-application context has full privilege.
// - Reset leaves the core in supervisor context.
// - Debug state grants access to all registers and privileged instructions.
// - Debug entry sets the debug flag and jumps to the debug handler.
// - Debug runs in exception context, saving return state to debug registers.
// - Debug lets the status mode bits change freely under full privilege.
// - Return from debug restores the context active before debug entry.
// - Fetch starts after reset at 0x8000_0000.
// - Miss exceptions and supervisor calls vector to fixed base-relative entries.
// - Each exception source has its own distinct handler address.
// - Region unit signals protection, miss and multiple-hit exceptions per side.
// - Interrupt handler is event base plus the controller's 14-bit offset.
// - Several events on one instruction are serviced in fixed priority.
// - Events of the oldest instruction are serviced before younger ones.
// - No translation, coprocessor or floating point exceptions exist.
`timescale 1ns/1ps
module cmec_core
  import cmec_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Pipeline stages: older carries the data access, younger the fetch
  input  wire cmec_stage_t older_stage,
  input  wire cmec_stage_t younger_stage,
  // Interrupt controller and debug
  input  wire cmec_irq_t   irq,
  input  wire logic        nmi_req,
  input  wire logic        debug_req,
  input  wire logic        retd,
  input  wire logic        rete,
  input  wire logic        sysreg_access,
  // Mode and redirect outputs
  output cmec_mode_t       cur_mode,
  output logic             privileged,
  output logic             debug_state_flag,
  output logic             instr_refuse,
  output logic             sysreg_refuse,
  output logic             redirect,
  output logic [31:0]      redirect_addr,
  output logic [4:0]       cause
);

  cmec_state_t s_q;
  cmec_state_t s_d;

  logic                 sys_q;
  logic [31:0]          sw_q;
  logic [CMEC_NREG-1:0] i_viol;
  logic [CMEC_NREG-1:0] d_viol;
  logic [CMEC_NEXC-1:0] i_evt;
  logic [CMEC_NEXC-1:0] d_evt;
  logic [CMEC_NEXC-1:0] sel_evt;
  logic [31:0]          sel_pc;
  logic [3:0]           sel_idx;
  logic [1:0]           irq_lvl;
  logic                 irq_any;
  cmec_mode_t           irq_mode;
  logic [2:0]           rank_q;
  logic                 take_dbg;
  logic                 take_nmi;
  logic                 take_exc;
  logic                 take_irq;
  logic                 acc;
  logic [31:0]          rd;
  logic [31:0]          sw_d;
  logic                 sys_d;

  function automatic logic [31:0] pack_sw(input cmec_state_t s);
    logic [31:0] w;
    w = '0;
    w[CMEC_SR_LOW_W-1:0]  = s.low;
    w[CMEC_SR_GM]         = s.gm;
    w[CMEC_SR_IM +: 4]    = s.im;
    w[CMEC_SR_MODE +: 3]  = s.mode;
    w[CMEC_SR_D]          = s.dbg;
    return w;
  endfunction

  function automatic logic [3:0] hit_count(input logic [CMEC_NREG-1:0] h);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < CMEC_NREG; i++) begin
      n = n + {3'h0, h[i]};
    end
    return n;
  endfunction

  // Full privilege outside application context or inside debug state
  assign sys_q  = (s_q.mode != CMEC_APP) || s_q.dbg;
  assign sw_q   = pack_sw(s_q);
  assign rank_q = cmec_rank(s_q.mode);

  // Per-region violation: hit without permission, or a system region from application
  for (genvar r = 0; r < CMEC_NREG; r++) begin : g_region
    assign i_viol[r] = younger_stage.region_hit[r] &
                       (~younger_stage.region_ok[r] | (younger_stage.region_sys[r] & ~sys_q));
    assign d_viol[r] = older_stage.region_hit[r] &
                       (~older_stage.region_ok[r] | (older_stage.region_sys[r] & ~sys_q));
  end

  // Build each stage's event set; only the listed sources can ever be raised
  always_comb begin
    logic [3:0] ni;
    logic [3:0] nd;
    ni    = hit_count(younger_stage.region_hit);
    nd    = hit_count(older_stage.region_hit);
    i_evt = younger_stage.ext_evt;
    d_evt = older_stage.ext_evt;
    if (younger_stage.access) begin
      i_evt[CMEC_X_IMISS]  = i_evt[CMEC_X_IMISS] | (ni == 4'h0);
      i_evt[CMEC_X_IMULTI] = i_evt[CMEC_X_IMULTI] | (ni > 4'h1);
      i_evt[CMEC_X_IPROT]  = i_evt[CMEC_X_IPROT] | ((ni == 4'h1) & (|i_viol));
    end
    if (older_stage.access) begin
      d_evt[CMEC_X_DMISS]  = d_evt[CMEC_X_DMISS] | (nd == 4'h0);
      d_evt[CMEC_X_DMULTI] = d_evt[CMEC_X_DMULTI] | (nd > 4'h1);
      d_evt[CMEC_X_DPROT]  = d_evt[CMEC_X_DPROT] | ((nd == 4'h1) & (|d_viol));
    end
    d_evt[CMEC_X_PRIV] = d_evt[CMEC_X_PRIV] | (older_stage.priv_instr & ~sys_q);
  end

  // Oldest instruction first, then fixed source order within it
  always_comb begin
    sel_evt = (|d_evt) ? d_evt : i_evt;
    sel_pc  = (|d_evt) ? older_stage.pc : younger_stage.pc;
    sel_idx = '0;
    for (int i = CMEC_NEXC - 1; i >= 0; i--) begin
      if (sel_evt[i]) begin
        sel_idx = 4'(i);
      end
    end
  end

  // Highest unmasked interrupt level
  always_comb begin
    irq_lvl = '0;
    irq_any = 1'b0;
    for (int l = 0; l < 4; l++) begin
      if (irq.req[l] & ~s_q.im[l] & ~s_q.gm) begin
        irq_lvl = 2'(l);
        irq_any = 1'b1;
      end
    end
    irq_mode = cmec_irq_mode(irq_lvl);
  end

  // Debug first, then NMI, exceptions, interrupts
  assign take_dbg = debug_req & ~s_q.dbg;
  assign take_nmi = ~take_dbg & nmi_req & ~s_q.dbg & (s_q.mode != CMEC_NMI);
  assign take_exc = ~take_dbg & ~take_nmi & (|sel_evt);
  assign take_irq = ~take_dbg & ~take_nmi & ~take_exc & irq_any & ~s_q.dbg &
                    (cmec_rank(irq_mode) < rank_q);
  assign acc      = hsel & htrans[1] & hready & (hsize == CMEC_HSIZE_WORD);

  always_comb begin
    s_d       = s_q;
    s_d.redir = 1'b0;
    rd        = '0;
    // Data phase of a register write
    if (s_q.dph_wr) begin
      case (s_q.dph_addr)
        CMEC_REG_VBASE: begin
          if (s_q.dph_ok) begin
            s_d.vbase = hwdata;
          end
        end
        CMEC_REG_STATUS: begin
          s_d.low = hwdata[CMEC_SR_LOW_W-1:0];
          if (s_q.dph_ok) begin
            s_d.gm   = hwdata[CMEC_SR_GM];
            s_d.im   = hwdata[CMEC_SR_IM +: 4];
            s_d.mode = cmec_mode_t'(hwdata[CMEC_SR_MODE +: 3]);
          end
        end
        CMEC_REG_DRA: begin
          if (s_q.dph_ok) begin
            s_d.dra = hwdata;
          end
        end
        CMEC_REG_DRS: begin
          if (s_q.dph_ok) begin
            s_d.drs = hwdata;
          end
        end
        CMEC_REG_ERA: begin
          if (s_q.dph_ok) begin
            s_d.era = hwdata;
          end
        end
        CMEC_REG_ERS: begin
          if (s_q.dph_ok) begin
            s_d.ers = hwdata;
          end
        end
        default: begin
        end
      endcase
    end
    // Event entry and return; hardware updates win over a same-cycle write
    if (take_dbg) begin
      s_d.drs        = sw_q;
      s_d.dra        = older_stage.pc;
      s_d.dbg        = 1'b1;
      s_d.mode       = CMEC_EXC;
      s_d.gm         = 1'b1;
      s_d.redir      = 1'b1;
      s_d.redir_addr = s_q.vbase + {18'h0, CMEC_DBG_OFF};
      s_d.cause      = CMEC_CAUSE_DBG;
    end else if (take_nmi) begin
      s_d.ers        = sw_q;
      s_d.era        = older_stage.pc;
      s_d.mode       = CMEC_NMI;
      s_d.gm         = 1'b1;
      s_d.redir      = 1'b1;
      s_d.redir_addr = s_q.vbase + {18'h0, CMEC_NMI_OFF};
      s_d.cause      = CMEC_CAUSE_NMI;
    end else if (take_exc) begin
      s_d.ers = sw_q;
      s_d.era = sel_pc;
      s_d.gm  = 1'b1;
      // A supervisor call from application lands in supervisor context
      if (sel_idx == 4'(CMEC_X_SCALL)) begin
        if (s_q.mode == CMEC_APP) begin
          s_d.mode = CMEC_SUP;
        end
      end else if (cmec_rank(CMEC_EXC) < rank_q) begin
        s_d.mode = CMEC_EXC;
      end
      s_d.redir      = 1'b1;
      s_d.redir_addr = s_q.vbase + {18'h0, CMEC_EXC_OFF[sel_idx]};
      s_d.cause      = {1'b0, sel_idx};
    end else if (take_irq) begin
      s_d.ers        = sw_q;
      s_d.era        = older_stage.pc;
      s_d.mode       = irq_mode;
      s_d.redir      = 1'b1;
      s_d.redir_addr = s_q.vbase + {18'h0, irq.offset};
      s_d.cause      = CMEC_CAUSE_IRQ + {3'h0, irq_lvl};
    end else if (retd & s_q.dbg) begin
      s_d.dbg        = 1'b0;
      s_d.mode       = cmec_mode_t'(s_q.drs[CMEC_SR_MODE +: 3]);
      s_d.gm         = s_q.drs[CMEC_SR_GM];
      s_d.im         = s_q.drs[CMEC_SR_IM +: 4];
      s_d.redir      = 1'b1;
      s_d.redir_addr = s_q.dra;
    end else if (rete & sys_q & ~s_q.dbg) begin
      s_d.mode       = cmec_mode_t'(s_q.ers[CMEC_SR_MODE +: 3]);
      s_d.gm         = s_q.ers[CMEC_SR_GM];
      s_d.im         = s_q.ers[CMEC_SR_IM +: 4];
      s_d.redir      = 1'b1;
      s_d.redir_addr = s_q.era;
    end
    // Address phase; reads see the next state so a write just before is visible
    sw_d  = pack_sw(s_d);
    sys_d = (s_d.mode != CMEC_APP) || s_d.dbg;
    case (haddr[7:0])
      CMEC_REG_STATUS: rd = sys_d ? sw_d : {16'h0000, s_d.low};
      CMEC_REG_VBASE:  rd = sys_d ? s_d.vbase : '0;
      CMEC_REG_DRA:    rd = sys_d ? s_d.dra : '0;
      CMEC_REG_DRS:    rd = sys_d ? s_d.drs : '0;
      CMEC_REG_ERA:    rd = sys_d ? s_d.era : '0;
      CMEC_REG_ERS:    rd = sys_d ? s_d.ers : '0;
      CMEC_REG_CAUSE:  rd = sys_d ? {27'h0, s_d.cause} : '0;
      default:         rd = '0;
    endcase
    s_d.dph_wr   = acc & hwrite;
    s_d.dph_ok   = sys_d;
    s_d.dph_addr = haddr[7:0];
    if (acc & ~hwrite) begin
      s_d.hrdata = rd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q            <= '0;
      s_q.mode       <= CMEC_SUP;
      s_q.gm         <= 1'b1;
      s_q.redir      <= 1'b1;
      s_q.redir_addr <= CMEC_RESET_ADDR;
      s_q.cause      <= CMEC_CAUSE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = s_q.hrdata;
  assign cur_mode         = s_q.mode;
  assign privileged       = sys_q;
  assign debug_state_flag = s_q.dbg;
  assign instr_refuse     = older_stage.priv_instr & ~sys_q;
  assign sysreg_refuse    = sysreg_access & ~sys_q;
  assign redirect         = s_q.redir;
  assign redirect_addr    = s_q.redir_addr;
  assign cause            = s_q.cause;

  // Assertion helper: high during reset and in the first cycle after reset release
  logic boot_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  property p_boot;
    @(posedge hclk) disable iff (!hresetn)
    boot_q |-> redirect && redirect_addr == CMEC_RESET_ADDR && cur_mode == CMEC_SUP;
  endproperty
  a_boot: assert property (p_boot) else $error("reset entry wrong");

  property p_no_lower;
    @(posedge hclk) disable iff (!hresetn)
    take_irq |=> cmec_rank(cur_mode) < $past(rank_q);
  endproperty
  a_no_lower: assert property (p_no_lower) else $error("lower mode preempted");

  property p_nmi;
    @(posedge hclk) disable iff (!hresetn)
    (nmi_req && !debug_req && !debug_state_flag && cur_mode != CMEC_NMI) |=>
      cur_mode == CMEC_NMI && redirect;
  endproperty
  a_nmi: assert property (p_nmi) else $error("NMI not taken");

  property p_dbg_entry;
    @(posedge hclk) disable iff (!hresetn)
    (debug_req && !debug_state_flag) |=> debug_state_flag && cur_mode == CMEC_EXC &&
      redirect && redirect_addr == $past(s_q.vbase) + {18'h0, CMEC_DBG_OFF};
  endproperty
  a_dbg_entry: assert property (p_dbg_entry) else $error("debug entry wrong");

  property p_dbg_save;
    @(posedge hclk) disable iff (!hresetn)
    (debug_req && !debug_state_flag) |=> s_q.drs == $past(sw_q) &&
      s_q.dra == $past(older_stage.pc);
  endproperty
  a_dbg_save: assert property (p_dbg_save) else $error("debug save wrong");

  property p_retd;
    @(posedge hclk) disable iff (!hresetn)
    (retd && debug_state_flag && !take_exc && !nmi_req) |=> !debug_state_flag &&
      cur_mode == cmec_mode_t'($past(s_q.drs[CMEC_SR_MODE +: 3])) &&
      redirect_addr == $past(s_q.dra);
  endproperty
  a_retd: assert property (p_retd) else $error("retd restore wrong");

  property p_irq_vec;
    @(posedge hclk) disable iff (!hresetn)
    take_irq |=> redirect && redirect_addr == $past(s_q.vbase) + {18'h0, $past(irq.offset)};
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("irq vector wrong");

  property p_oldest;
    @(posedge hclk) disable iff (!hresetn)
    (take_exc && |d_evt) |=> s_q.era == $past(older_stage.pc);
  endproperty
  a_oldest: assert property (p_oldest) else $error("younger event served first");

  property p_app_refuse;
    @(posedge hclk) disable iff (!hresetn)
    ((cur_mode == CMEC_APP && !debug_state_flag && sysreg_access) |-> sysreg_refuse) and
      ((s_q.dph_wr && !s_q.dph_ok) |=> $stable(s_q.vbase));
  endproperty
  a_app_refuse: assert property (p_app_refuse) else $error("app reached sysreg");

endmodule // cmec_core

// *** shared/cmec_pkg.sv ***
// Shared constants, types and helpers for the mode and event control unit
package cmec_pkg;

  // Execution contexts, Gray coded along the priority ladder
  typedef enum logic [2:0] {
    CMEC_SUP  = 3'h0,
    CMEC_APP  = 3'h1,
    CMEC_INT0 = 3'h3,
    CMEC_INT1 = 3'h2,
    CMEC_INT2 = 3'h6,
    CMEC_INT3 = 3'h7,
    CMEC_EXC  = 3'h5,
    CMEC_NMI  = 3'h4
  } cmec_mode_t;

  localparam logic [31:0] CMEC_RESET_ADDR = 32'h8000_0000;

  // Register byte offsets (decoded on haddr[7:0])
  localparam logic [7:0] CMEC_REG_VBASE  = 8'h00;
  localparam logic [7:0] CMEC_REG_STATUS = 8'h04;
  localparam logic [7:0] CMEC_REG_DRA    = 8'h08;
  localparam logic [7:0] CMEC_REG_DRS    = 8'h0C;
  localparam logic [7:0] CMEC_REG_ERA    = 8'h10;
  localparam logic [7:0] CMEC_REG_ERS    = 8'h14;
  localparam logic [7:0] CMEC_REG_CAUSE  = 8'h18;
  localparam logic [2:0] CMEC_HSIZE_WORD = 3'h2;

  // Status word fields
  localparam int CMEC_SR_LOW_W = 16;
  localparam int CMEC_SR_GM    = 16;
  localparam int CMEC_SR_IM    = 17;
  localparam int CMEC_SR_MODE  = 22;
  localparam int CMEC_SR_D     = 27;

  // Exception sources; a lower index is serviced first
  localparam int CMEC_X_IMULTI  = 0;
  localparam int CMEC_X_IMISS   = 1;
  localparam int CMEC_X_IPROT   = 2;
  localparam int CMEC_X_ILLEGAL = 3;
  localparam int CMEC_X_PRIV    = 4;
  localparam int CMEC_X_DMULTI  = 5;
  localparam int CMEC_X_DMISS   = 6;
  localparam int CMEC_X_DPROT   = 7;
  localparam int CMEC_X_SCALL   = 8;
  localparam int CMEC_NEXC      = 9;
  localparam int CMEC_NREG      = 8;

  // Handler offsets from the event vector base, one distinct entry per source
  localparam logic [13:0] CMEC_EXC_OFF [CMEC_NEXC] = '{
    14'h0004, 14'h0050, 14'h0008, 14'h000C, 14'h0014,
    14'h0018, 14'h0060, 14'h0020, 14'h0100};
  localparam logic [13:0] CMEC_NMI_OFF = 14'h0010;
  localparam logic [13:0] CMEC_DBG_OFF = 14'h001C;

  localparam logic [4:0] CMEC_CAUSE_RESET = 5'h10;
  localparam logic [4:0] CMEC_CAUSE_NMI   = 5'h11;
  localparam logic [4:0] CMEC_CAUSE_DBG   = 5'h12;
  localparam logic [4:0] CMEC_CAUSE_IRQ   = 5'h14;
  localparam logic [2:0] CMEC_RANK_NONE   = 3'h7;

  // One pipeline stage as seen by event control
  typedef struct packed {
    logic [31:0]           pc;
    logic [CMEC_NEXC-1:0]  ext_evt;
    logic                  access;
    logic                  priv_instr;
    logic [CMEC_NREG-1:0]  region_hit;
    logic [CMEC_NREG-1:0]  region_ok;
    logic [CMEC_NREG-1:0]  region_sys;
  } cmec_stage_t;

  // Interrupt controller request: offset belongs to the highest pending level
  typedef struct packed {
    logic [3:0]  req;
    logic [13:0] offset;
  } cmec_irq_t;

  typedef struct packed {
    cmec_mode_t  mode;
    logic        dbg;
    logic        gm;
    logic [3:0]  im;
    logic [15:0] low;
    logic [31:0] vbase;
    logic [31:0] dra;
    logic [31:0] drs;
    logic [31:0] era;
    logic [31:0] ers;
    logic [4:0]  cause;
    logic        redir;
    logic [31:0] redir_addr;
    logic        dph_wr;
    logic        dph_ok;
    logic [7:0]  dph_addr;
    logic [31:0] hrdata;
  } cmec_state_t;

  function automatic logic [2:0] cmec_rank(input cmec_mode_t m);
    case (m)
      CMEC_NMI:  cmec_rank = 3'h1;
      CMEC_EXC:  cmec_rank = 3'h2;
      CMEC_INT3: cmec_rank = 3'h3;
      CMEC_INT2: cmec_rank = 3'h4;
      CMEC_INT1: cmec_rank = 3'h5;
      CMEC_INT0: cmec_rank = 3'h6;
      default:   cmec_rank = CMEC_RANK_NONE;
    endcase
  endfunction

  function automatic cmec_mode_t cmec_irq_mode(input logic [1:0] lvl);
    case (lvl)
      2'h3:    cmec_irq_mode = CMEC_INT3;
      2'h2:    cmec_irq_mode = CMEC_INT2;
      2'h1:    cmec_irq_mode = CMEC_INT1;
      default: cmec_irq_mode = CMEC_INT0;
    endcase
  endfunction

endpackage

// *** sim/cmec_irq_ctrl_model.sv ***
// Behavioural interrupt controller that feeds requests and autovector offsets
`timescale 1ns/1ps
module cmec_irq_ctrl_model
  import cmec_pkg::*;
(
  // Request side driven by the bench
  input  wire logic [3:0]  pend,
  input  wire logic [55:0] offs,
  // Towards the core
  output cmec_irq_t        irq
);
  always_comb begin
    irq.req    = pend;
    // No request pending: the offset is not held, show a pattern that differs from the level 0 entry
    irq.offset = ~offs[13:0];
    for (int l = 0; l < 4; l++) begin
      if (pend[l]) begin
        irq.offset = offs[l*14 +: 14];
      end
    end
  end
endmodule // cmec_irq_ctrl_model

// *** sim/tb_cpu_mode_event_control.sv ***
// Self-checking bench for the mode and event control unit
`timescale 1ns/1ps
module tb_cpu_mode_event_control
  import cmec_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, redirect_addr, ev_base, pc_v, rd_v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        nmi_req, debug_req, retd, rete, sysreg_access;
  logic        privileged, debug_state_flag, instr_refuse, sysreg_refuse, redirect;
  logic [4:0]  cause;
  logic [3:0]  pend;
  logic [55:0] offs;
  cmec_stage_t older, younger;
  cmec_irq_t   irq_w;
  cmec_mode_t  cur_mode;
  int          seed, n_fail, comparisons;
  logic [7:0]  rh [4] = '{8'h00, 8'h03, 8'h01, 8'h01};
  logic [7:0]  ro [4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
  logic [7:0]  rs [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
  int          rc [4] = '{6, 5, 7, 7};

  cmec_core cmec_core_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .older_stage(older),
    .younger_stage(younger), .irq(irq_w), .nmi_req(nmi_req), .debug_req(debug_req),
    .retd(retd), .rete(rete), .sysreg_access(sysreg_access), .cur_mode(cur_mode),
    .privileged(privileged), .debug_state_flag(debug_state_flag),
    .instr_refuse(instr_refuse), .sysreg_refuse(sysreg_refuse), .redirect(redirect),
    .redirect_addr(redirect_addr), .cause(cause));

  cmec_irq_ctrl_model cmec_irq_ctrl_model_inst (.pend(pend), .offs(offs), .irq(irq_w));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Single word transfer; waits on hready, which this slave never lowers
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= CMEC_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd_v);
    check(name, rd_v, exp);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task set_mode(input cmec_mode_t m, input logic gm);
    bus(1'b1, CMEC_REG_STATUS, {7'h0, m, 5'h0, gm, 16'h0}, rd_v);
  endtask

  // Stimulus was set by the caller after the previous edge; this edge takes it
  task ev(input logic [31:0] a, input cmec_mode_t m, input logic [5:0] c);
    @(posedge hclk);
    nmi_req         <= 1'b0;
    debug_req       <= 1'b0;
    retd            <= 1'b0;
    rete            <= 1'b0;
    older.ext_evt   <= '0;
    older.access    <= 1'b0;
    younger.ext_evt <= '0;
    younger.access  <= 1'b0;
    #1;
    check("redirect", {31'h0, redirect}, 32'h1);
    check("redirect_addr", redirect_addr, a);
    check("cur_mode", {29'h0, cur_mode}, {29'h0, m});
    if (!c[5]) check("cause", {27'h0, cause}, {27'h0, c[4:0]});
  endtask

  function automatic logic [31:0] vec(input logic [13:0] off);
    return ev_base + {18'h0, off};
  endfunction

  // Whole run is under two hundred cycles; this bound only cuts a hang short
  initial begin
    #100000;
    n_fail++;
    summarize();
  end

  initial begin
    seed = 86614;
    n_fail = 0;
    comparisons = 0;
    hresetn = 1'b0;
    {hsel, hwrite, nmi_req, debug_req, retd, rete, sysreg_access} = '0;
    {haddr, hwdata, htrans, hsize, pend} = '0;
    older = '0;
    younger = '0;
    ev_base = $random(seed) & 32'h7FFF_FF00;
    for (int l = 0; l < 4; l++) offs[l*14 +: 14] = 14'($random(seed)) & 14'h3FFC;
    repeat (19) @(posedge hclk);
    #1;
    check("reset_mode", {29'h0, cur_mode}, {29'h0, CMEC_SUP});
    check("reset_addr", redirect_addr, 32'h8000_0000);
    check("reset_redirect", {31'h0, redirect}, 32'h1);
    check("reset_priv", {31'h0, privileged}, 32'h1);
    check("reset_dbg", {31'h0, debug_state_flag}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, CMEC_REG_VBASE, ev_base, rd_v);
    rd_chk("vbase", CMEC_REG_VBASE, ev_base);
    rd_chk("status", CMEC_REG_STATUS, 32'h0001_0000);
    rd_chk("unmapped", 8'h1C, 32'h0);
    bus(1'b1, CMEC_REG_CAUSE, 32'hFFFF_FFFF, rd_v);
    rd_chk("cause_ro", CMEC_REG_CAUSE, {27'h0, CMEC_CAUSE_RESET});
    set_mode(CMEC_APP, 1'b0);
    @(posedge hclk);
    #1;
    check("app_mode", {29'h0, cur_mode}, {29'h0, CMEC_APP});
    check("app_priv", {31'h0, privileged}, 32'h0);
    rd_chk("app_vbase", CMEC_REG_VBASE, 32'h0);
    // Dropped write: every later vector still uses ev_base
    bus(1'b1, CMEC_REG_VBASE, ~ev_base, rd_v);
    bus(1'b1, CMEC_REG_STATUS, 32'h1234_ABCD, rd_v);
    rd_chk("app_status", CMEC_REG_STATUS, 32'h0000_ABCD);
    // Interrupt ladder: enter level 1, lower level held off, level 3 preempts
    pc_v = $random(seed) & 32'hFFFF_FFFC;
    @(posedge hclk);
    older.pc <= pc_v;
    pend     <= 4'h2;
    ev(vec(offs[14 +: 14]), CMEC_INT1, {1'b0, CMEC_CAUSE_IRQ + 5'h1});
    @(posedge hclk);
    pend <= 4'h1;
    repeat (3) begin
      @(posedge hclk);
      #1;
      check("no_preempt", {31'h0, redirect}, 32'h0);
    end
    check("int1_kept", {29'h0, cur_mode}, {29'h0, CMEC_INT1});
    @(posedge hclk);
    pend <= 4'h8;
    ev(vec(offs[42 +: 14]), CMEC_INT3, {1'b0, CMEC_CAUSE_IRQ + 5'h3});
    @(posedge hclk);
    pend <= 4'h0;
    rete <= 1'b1;
    ev(pc_v, CMEC_INT1, 6'h20);
    set_mode(CMEC_SUP, 1'b1);
    pend <= 4'h8;
    @(posedge hclk);
    #1;
    check("gm_blocks_irq", {31'h0, redirect}, 32'h0);
    @(posedge hclk);
    pend    <= 4'h0;
    nmi_req <= 1'b1;
    ev(vec(CMEC_NMI_OFF), CMEC_NMI, {1'b0, CMEC_CAUSE_NMI});
    for (int i = 0; i < CMEC_NEXC; i++) begin
      set_mode(CMEC_SUP, 1'b0);
      @(posedge hclk);
      older.ext_evt <= 9'(1 << i);
      ev(vec(CMEC_EXC_OFF[i]), (i == CMEC_X_SCALL) ? CMEC_SUP : CMEC_EXC, 6'(i));
    end
    set_mode(CMEC_SUP, 1'b0);
    @(posedge hclk);
    older.ext_evt <= 9'h1A0;
    ev(vec(CMEC_EXC_OFF[5]), CMEC_EXC, 6'h05);
    set_mode(CMEC_SUP, 1'b0);
    @(posedge hclk);
    older.ext_evt   <= 9'h040;
    younger.ext_evt <= 9'h001;
    ev(vec(CMEC_EXC_OFF[6]), CMEC_EXC, 6'h06);
    // Region unit outcomes: miss, multiple hit, violation, system region from application
    for (int k = 0; k < 4; k++) begin
      set_mode((k == 3) ? CMEC_APP : CMEC_SUP, 1'b0);
      @(posedge hclk);
      older.access     <= 1'b1;
      older.region_hit <= rh[k];
      older.region_ok  <= ro[k];
      older.region_sys <= rs[k];
      ev(vec(CMEC_EXC_OFF[rc[k]]), CMEC_EXC, 6'(rc[k]));
    end
    // Fetch side: two regions hit at once
    set_mode(CMEC_SUP, 1'b0);
    @(posedge hclk);
    younger.access     <= 1'b1;
    younger.region_hit <= 8'h06;
    ev(vec(CMEC_EXC_OFF[CMEC_X_IMULTI]), CMEC_EXC, 6'(CMEC_X_IMULTI));
    set_mode(CMEC_APP, 1'b0);
    @(posedge hclk);
    older.priv_instr <= 1'b1;
    sysreg_access    <= 1'b1;
    #1;
    check("instr_refuse", {31'h0, instr_refuse}, 32'h1);
    check("sysreg_refuse", {31'h0, sysreg_refuse}, 32'h1);
    @(posedge hclk);
    older.priv_instr <= 1'b0;
    sysreg_access    <= 1'b0;
    // Debug round trip; mode bits are rewritten while inside
    set_mode(CMEC_SUP, 1'b0);
    pc_v = $random(seed) & 32'hFFFF_FFFC;
    @(posedge hclk);
    older.pc  <= pc_v;
    debug_req <= 1'b1;
    ev(vec(CMEC_DBG_OFF), CMEC_EXC, {1'b0, CMEC_CAUSE_DBG});
    check("dbg_flag", {31'h0, debug_state_flag}, 32'h1);
    rd_chk("dbg_ret_addr", CMEC_REG_DRA, pc_v);
    bus(1'b1, CMEC_REG_STATUS, 32'h0840_0000, rd_v);
    @(posedge hclk);
    older.priv_instr <= 1'b1;
    #1;
    check("dbg_mode", {29'h0, cur_mode}, {29'h0, CMEC_APP});
    check("dbg_priv", {31'h0, privileged}, 32'h1);
    check("dbg_refuse", {31'h0, instr_refuse}, 32'h0);
    @(posedge hclk);
    older.priv_instr <= 1'b0;
    retd             <= 1'b1;
    ev(pc_v, CMEC_SUP, 6'h20);
    check("dbg_exit", {31'h0, debug_state_flag}, 32'h0);
    summarize();
  end
endmodule // tb_cpu_mode_event_control
